/* File: sfh_consts.svh */
`ifndef SFH_CONSTS_SVH
`define SFH_CONSTS_SVH

// lane widths of a phase
`define SFH_LANE1          3'h1
`define SFH_LANE2          3'h2
`define SFH_LANE4          3'h4

// clock and timing, in ns and derived cycles
`define SFH_CLK_NS         100
`define SFH_SCK_HALF_CYC   4'h4
`define SFH_SCK_MID_CYC    4'h2
`define SFH_CS_SETUP_NS    100
`define SFH_CS_SETUP_CYC   ((`SFH_CS_SETUP_NS + `SFH_CLK_NS - 1) / `SFH_CLK_NS)
`define SFH_CS_HIGH_NS     300
`define SFH_CS_HIGH_CYC    ((`SFH_CS_HIGH_NS + `SFH_CLK_NS - 1) / `SFH_CLK_NS)

// bits of one byte, used by every byte-wide phase
`define SFH_BYTE_BITS      6'h08

`endif

/* File: sfh_pkg.sv */
package sfh_pkg;

  // one-hot phases, ascending in command order
  typedef enum logic [9:0] {
    PH_IDLE   = 10'h001,
    PH_SETUP  = 10'h002,
    PH_INSTR  = 10'h004,
    PH_ADDR   = 10'h008,
    PH_MODE   = 10'h010,
    PH_DUMMY  = 10'h020,
    PH_WRITE  = 10'h040,
    PH_READ   = 10'h080,
    PH_FINISH = 10'h100,
    PH_CSHIGH = 10'h200
  } sfh_phase_e;

  typedef logic [2:0] sfh_lanes_t;

  typedef struct packed {
    logic [1:0] rst_sh;
    logic [3:0] io_meta;
    logic [3:0] io_sync;
  } sfh_sync_s;

  typedef struct packed {
    logic       sck;
    logic [3:0] cnt;
  } sfh_sck_s;

  typedef struct packed {
    sfh_phase_e  ph;
    logic        cs_n;
    logic [31:0] sh;
    logic [6:0]  units;
    logic [15:0] bytes;
    logic        pend;
    logic        skipf;
    logic [7:0]  rsh;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        done;
    logic [3:0]  wait_cnt;
    logic [7:0]  instr;
    logic [31:0] addr;
    logic [2:0]  ab;
    sfh_lanes_t  wa;
    sfh_lanes_t  wd;
    logic        mode_en;
    logic [7:0]  mode;
    logic [4:0]  dummy;
    logic        ddr;
    logic        all_four_lane_mode;
    logic        quad;
    logic        cont;
    logic        cpol;
    logic [15:0] wr_len;
    logic [15:0] rd_len;
    logic [3:0]  io_out;
    logic [3:0]  io_oe;
  } sfh_ctrl_s;

endpackage : sfh_pkg

/* File: sfh_sync.sv */
`timescale 1ns/10ps
`include "sfh_consts.svh"

module sfh_sync
  import sfh_pkg::*;
(
  // clock and raw reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // pin inputs
  input  wire logic [3:0] io_i,
  // synchronised copies
  output logic            rst_n_o,
  output logic [3:0]      io_o
);

  sfh_sync_s st_r;
  sfh_sync_s st_nxt;

  // the meta stage feeds only the second stage
  always_comb begin
    st_nxt         = st_r;
    st_nxt.rst_sh  = {st_r.rst_sh[0], 1'b1};
    st_nxt.io_meta = io_i;
    st_nxt.io_sync = st_r.io_meta;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rst_n_o = st_r.rst_sh[1];
  assign io_o    = st_r.io_sync;

endmodule : sfh_sync

/* File: sfh_sck_gen.sv */
`timescale 1ns/10ps
`include "sfh_consts.svh"

module sfh_sck_gen
  import sfh_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // control
  input  wire logic run_i,
  input  wire logic hold_i,
  input  wire logic cpol_i,
  // link clock and its events
  output logic      sck_o,
  output logic      rise_o,
  output logic      fall_o,
  output logic      mid_o,
  output logic      active_o
);

  sfh_sck_s st_r;
  sfh_sck_s st_nxt;
  logic     edge_w;

  // keeps toggling after run drops until SCK is back at its park level
  assign active_o = run_i || (st_r.sck != cpol_i);
  assign edge_w   = active_o && (st_r.cnt == (`SFH_SCK_HALF_CYC - 4'h1));
  assign rise_o   = edge_w && !st_r.sck;
  assign fall_o   = edge_w && st_r.sck;
  assign mid_o    = active_o && (st_r.cnt == `SFH_SCK_MID_CYC);
  assign sck_o    = st_r.sck;

  // hold freezes at mid-phase only, so no edge is ever stretched short
  always_comb begin
    st_nxt = st_r;
    if (!active_o) begin
      st_nxt.sck = cpol_i;
      st_nxt.cnt = 4'h0;
    end else if (!hold_i) begin
      if (edge_w) begin
        st_nxt.cnt = 4'h0;
        st_nxt.sck = ~st_r.sck;
      end else begin
        st_nxt.cnt = st_r.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : sfh_sck_gen

/* File: sfh_ctrl.sv */
`timescale 1ns/10ps
`include "sfh_consts.svh"

module sfh_ctrl
  import sfh_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // command request
  input  wire logic        start_i,
  output logic             cmd_ready_o,
  input  wire logic [7:0]  instr_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [2:0]  addr_bytes_i,
  input  wire logic [2:0]  addr_lanes_i,
  input  wire logic [2:0]  data_lanes_i,
  input  wire logic        mode_en_i,
  input  wire logic [7:0]  mode_i,
  input  wire logic [4:0]  dummy_i,
  input  wire logic        ddr_i,
  input  wire logic        cont_i,
  input  wire logic [15:0] wr_len_i,
  input  wire logic [15:0] rd_len_i,
  input  wire logic        cpol_i,
  // lane configuration of the memory
  input  wire logic        four_lane_enable_bit_i,
  input  wire logic        all_four_lane_mode_i,
  // write data stream
  input  wire logic [7:0]  wr_data_i,
  input  wire logic        wr_valid_i,
  output logic             wr_ready_o,
  // read data and completion
  output logic [7:0]       rd_data_o,
  output logic             rd_valid_o,
  output logic             done_o,
  // memory pins
  output logic             sck_o,
  output logic             cs_n_o,
  input  wire logic [3:0]  io_i,
  output logic [3:0]       io_o,
  output logic [3:0]       io_oe_o
);

  sfh_ctrl_s  st_r;
  sfh_ctrl_s  st_nxt;
  logic       rst_n_s;
  logic [3:0] io_s;
  logic       run_w;
  logic       hold_w;
  logic       take_w;
  logic       rise_w;
  logic       fall_w;
  logic       mid_w;
  logic       active_w;

  // lane width used by a phase
  function automatic sfh_lanes_t w_of(input sfh_ctrl_s st);
    if (st.ph == PH_INSTR) begin
      w_of = st.all_four_lane_mode ? `SFH_LANE4 : `SFH_LANE1;
    end else if (st.ph inside {PH_ADDR, PH_MODE, PH_DUMMY}) begin
      w_of = st.wa;
    end else begin
      w_of = st.wd;
    end
  endfunction : w_of

  // transfers needed to move a number of bits over w lanes
  function automatic logic [6:0] units_of(input logic [5:0] bits,
                                          input sfh_lanes_t w);
    case (w)
      `SFH_LANE2: units_of = {2'h0, bits[5:1]};
      `SFH_LANE4: units_of = {3'h0, bits[5:2]};
      default:    units_of = {1'h0, bits};
    endcase
  endfunction : units_of

  // drop the group just sent, next group comes up at the top
  function automatic logic [31:0] shl(input logic [31:0] sh,
                                      input sfh_lanes_t w);
    case (w)
      `SFH_LANE2: shl = {sh[29:0], 2'h0};
      `SFH_LANE4: shl = {sh[27:0], 4'h0};
      default:    shl = {sh[30:0], 1'h0};
    endcase
  endfunction : shl

  // MSB of the group lands on the highest lane, LSB on IO0
  function automatic logic [3:0] lanes_out(input logic [31:0] sh,
                                           input sfh_lanes_t w);
    case (w)
      `SFH_LANE2: lanes_out = {2'h0, sh[31:30]};
      `SFH_LANE4: lanes_out = sh[31:28];
      default:    lanes_out = {3'h0, sh[31]};
    endcase
  endfunction : lanes_out

  function automatic logic [3:0] lane_mask(input sfh_lanes_t w);
    case (w)
      `SFH_LANE2: lane_mask = 4'h3;
      `SFH_LANE4: lane_mask = 4'hF;
      default:    lane_mask = 4'h1;
    endcase
  endfunction : lane_mask

  // single lane reads come back on IO1, wider ones on the low lanes
  function automatic logic [7:0] gather(input logic [7:0] rsh,
                                        input logic [3:0] io,
                                        input sfh_lanes_t w);
    case (w)
      `SFH_LANE2: gather = {rsh[5:0], io[1:0]};
      `SFH_LANE4: gather = {rsh[3:0], io[3:0]};
      default:    gather = {rsh[6:0], io[1]};
    endcase
  endfunction : gather

  // phase that follows the current one; one-hot codes ascend in order
  function automatic sfh_phase_e next_ph(input sfh_ctrl_s st);
    if (st.ph < PH_ADDR && st.ab != 3'h0) begin
      next_ph = PH_ADDR;
    end else if (st.ph < PH_MODE && st.mode_en) begin
      next_ph = PH_MODE;
    end else if (st.ph < PH_DUMMY && st.dummy != 5'h00) begin
      next_ph = PH_DUMMY;
    end else if (st.ph < PH_WRITE && st.wr_len != 16'h0000) begin
      next_ph = PH_WRITE;
    end else if (st.ph < PH_WRITE && st.rd_len != 16'h0000) begin
      next_ph = PH_READ;
    end else begin
      next_ph = PH_FINISH;
    end
  endfunction : next_ph

  // load shift register and transfer count for a new phase
  function automatic sfh_ctrl_s enter(input sfh_ctrl_s  st,
                                      input sfh_phase_e tgt,
                                      input logic [7:0] wb);
    sfh_ctrl_s r;
    r       = st;
    // double rate skips the fall that closes the instruction cycle
    r.skipf = (st.ph == PH_INSTR) || (st.ph == PH_SETUP);
    r.pend  = 1'b0;
    r.ph    = tgt;
    case (tgt)
      PH_INSTR: begin
        r.sh    = {st.instr, 24'h000000};
        r.units = units_of(`SFH_BYTE_BITS, w_of(r));
      end
      PH_ADDR: begin
        // 24-bit addresses are left aligned so the MSB leaves first
        r.sh    = (st.ab == 3'h3) ? {st.addr[23:0], 8'h00} : st.addr;
        r.units = units_of({st.ab, 3'h0}, st.wa);
      end
      PH_MODE: begin
        r.sh    = {st.mode, 24'h000000};
        r.units = units_of(`SFH_BYTE_BITS, st.wa);
      end
      PH_DUMMY: begin
        r.sh    = 32'h00000000;
        r.units = st.ddr ? {1'h0, st.dummy, 1'h0} : {2'h0, st.dummy};
      end
      PH_WRITE: begin
        r.sh    = {wb, 24'h000000};
        r.bytes = st.wr_len;
        r.units = units_of(`SFH_BYTE_BITS, st.wd);
      end
      PH_READ: begin
        r.bytes = st.rd_len;
        r.units = units_of(`SFH_BYTE_BITS, st.wd);
      end
      default: begin
      end
    endcase
    enter = r;
  endfunction : enter

  // reset release and pin input synchronisers
  sfh_sync u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .io_i    (io_i),
    .rst_n_o (rst_n_s),
    .io_o    (io_s)
  );

  // link clock divided down from clk_i
  sfh_sck_gen u_sck (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_s),
    .run_i    (run_w),
    .hold_i   (hold_w),
    .cpol_i   (st_r.cpol),
    .sck_o    (sck_o),
    .rise_o   (rise_w),
    .fall_o   (fall_w),
    .mid_o    (mid_w),
    .active_o (active_w)
  );

  assign run_w = st_r.ph inside {PH_INSTR, PH_ADDR, PH_MODE, PH_DUMMY,
                                 PH_WRITE, PH_READ};

  // transfers: the memory takes a group on a latch edge, the host
  // moves to the next group at the middle of the following half period
  always_comb begin
    logic       lat;
    logic       step;
    logic [7:0] rs;
    sfh_phase_e tgt;
    sfh_lanes_t w;
    logic       drv;
    logic       quad_any;
    st_nxt          = st_r;
    st_nxt.rd_valid = 1'b0;
    st_nxt.done     = 1'b0;
    hold_w          = 1'b0;
    take_w          = 1'b0;
    rs              = 8'h00;
    tgt             = PH_FINISH;
    // instruction always on rises; later double rate phases on both
    lat  = rise_w || (st_r.ddr && st_r.ph != PH_INSTR && fall_w
                      && !st_r.skipf);
    step = mid_w && st_r.pend;
    unique case (st_r.ph)
      PH_IDLE: begin
        if (start_i) begin
          st_nxt.instr    = instr_i;
          st_nxt.addr     = addr_i;
          st_nxt.ab       = addr_bytes_i;
          st_nxt.all_four_lane_mode      = all_four_lane_mode_i;
          st_nxt.quad     = four_lane_enable_bit_i;
          st_nxt.wa       = all_four_lane_mode_i ? `SFH_LANE4
                                                 : addr_lanes_i;
          st_nxt.wd       = all_four_lane_mode_i ? `SFH_LANE4
                                                 : data_lanes_i;
          st_nxt.mode_en  = mode_en_i;
          st_nxt.mode     = mode_i;
          st_nxt.dummy    = dummy_i;
          st_nxt.ddr      = ddr_i;
          st_nxt.cont     = cont_i;
          st_nxt.cpol     = cpol_i;
          st_nxt.wr_len   = wr_len_i;
          st_nxt.rd_len   = rd_len_i;
          st_nxt.cs_n     = 1'b0;
          st_nxt.wait_cnt = 4'(`SFH_CS_SETUP_CYC);
          st_nxt.ph       = PH_SETUP;
        end
      end
      PH_SETUP: begin
        if (st_r.wait_cnt <= 4'h1) begin
          // continuous read opens straight with the address
          st_nxt = enter(st_r, st_r.cont ? PH_ADDR : PH_INSTR,
                         8'h00);
        end else begin
          st_nxt.wait_cnt = st_r.wait_cnt - 4'h1;
        end
      end
      PH_INSTR, PH_ADDR, PH_MODE, PH_DUMMY, PH_WRITE: begin
        if (lat) begin
          st_nxt.units = st_r.units - 7'h01;
          st_nxt.pend  = 1'b1;
          if (rise_w) begin
            st_nxt.skipf = 1'b0;
          end
        end
        if (step) begin
          st_nxt.pend = 1'b0;
          if (st_r.units != 7'h00) begin
            st_nxt.sh = shl(st_r.sh, w_of(st_r));
          end else if (st_r.ph == PH_WRITE && st_r.bytes != 16'h0001) begin
            // next write byte; stall SCK until the user has one
            if (wr_valid_i) begin
              take_w       = 1'b1;
              st_nxt.sh    = {wr_data_i, 24'h000000};
              st_nxt.bytes = st_r.bytes - 16'h0001;
              st_nxt.units = units_of(`SFH_BYTE_BITS, st_r.wd);
            end else begin
              hold_w      = 1'b1;
              st_nxt.pend = 1'b1;
            end
          end else begin
            tgt = next_ph(st_r);
            if (tgt == PH_WRITE && !wr_valid_i) begin
              hold_w      = 1'b1;
              st_nxt.pend = 1'b1;
            end else begin
              take_w = (tgt == PH_WRITE);
              st_nxt = enter(st_nxt, tgt, wr_data_i);
            end
          end
        end
      end
      PH_READ: begin
        if (lat) begin
          if (rise_w) begin
            st_nxt.skipf = 1'b0;
          end
          rs           = gather(st_r.rsh, io_s, st_r.wd);
          st_nxt.rsh   = rs;
          st_nxt.units = st_r.units - 7'h01;
          if (st_r.units == 7'h01) begin
            st_nxt.rd_data  = rs;
            st_nxt.rd_valid = 1'b1;
            if (st_r.bytes == 16'h0001) begin
              st_nxt.ph = PH_FINISH;
            end else begin
              st_nxt.bytes = st_r.bytes - 16'h0001;
              st_nxt.units = units_of(`SFH_BYTE_BITS, st_r.wd);
            end
          end
        end
      end
      PH_FINISH: begin
        // select rises only once SCK is parked; the count is whole clk_i cycles
        if (!active_w) begin
          st_nxt.cs_n     = 1'b1;
          st_nxt.wait_cnt = 4'(`SFH_CS_HIGH_CYC);
          st_nxt.ph       = PH_CSHIGH;
        end
      end
      PH_CSHIGH: begin
        if (st_r.wait_cnt <= 4'h1) begin
          st_nxt.done = 1'b1;
          st_nxt.ph   = PH_IDLE;
        end else begin
          st_nxt.wait_cnt = st_r.wait_cnt - 4'h1;
        end
      end
    endcase
    // pin drive follows the phase being entered, registered once
    w   = w_of(st_nxt);
    drv = st_nxt.ph inside {PH_INSTR, PH_ADDR, PH_MODE, PH_WRITE};
    st_nxt.io_out = drv ? lanes_out(st_nxt.sh, w) : 4'h0;
    st_nxt.io_oe  = drv ? lane_mask(w) : 4'h0;
    quad_any = (st_nxt.ph == PH_IDLE)
             ? (four_lane_enable_bit_i || all_four_lane_mode_i)
             : (st_nxt.quad || st_nxt.all_four_lane_mode);
    if (!quad_any) begin
      // write guard and reset pins held inactive high
      st_nxt.io_out[3:2] = 2'h3;
      st_nxt.io_oe[3:2]  = 2'h3;
    end else if (st_nxt.ph inside {PH_IDLE, PH_SETUP, PH_CSHIGH}) begin
      // IO2 is a data lane now; only IO3 stays driven high off-frame
      st_nxt.io_out[3] = 1'b1;
      st_nxt.io_oe[3]  = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_s) begin
    if (!rst_n_s) begin
      st_r <= '{ph: PH_IDLE, cs_n: 1'b1, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs
  assign cmd_ready_o = (st_r.ph == PH_IDLE);
  assign wr_ready_o  = take_w;
  assign rd_data_o   = st_r.rd_data;
  assign rd_valid_o  = st_r.rd_valid;
  assign done_o      = st_r.done;
  assign cs_n_o      = st_r.cs_n;
  assign io_o        = st_r.io_out;
  assign io_oe_o     = st_r.io_oe;

endmodule : sfh_ctrl

/* File: sfh_ctrl_monitor.sv */
`timescale 1ns/10ps
module sfh_ctrl_monitor (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  // command side
  input wire logic       start_i,
  input wire logic       cmd_ready_o,
  input wire logic [7:0] instr_i,
  input wire logic       cont_i,
  input wire logic       all_four_lane_mode_i,
  // streams
  input wire logic       wr_ready_o,
  input wire logic       rd_valid_o,
  input wire logic       done_o,
  // pins
  input wire logic       sck_o,
  input wire logic       cs_n_o,
  input wire logic [3:0] io_o,
  input wire logic [3:0] io_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // a request that the controller accepts
  sequence s_take;
    start_i && cmd_ready_o;
  endsequence
  // an explicit single lane instruction follows
  sequence s_explicit;
    s_take ##0 (!cont_i && !all_four_lane_mode_i);
  endsequence

  AST_CS_AFTER_TAKE: assert property (s_take |=> !cs_n_o)
    else $error("select did not fall after take");
  AST_INSTR_MSB: assert property (s_explicit |-> ##2
    (io_oe_o[0] && io_o[0] == $past(instr_i[7], 2)))
    else $error("first bit is not instruction msb");
  AST_CS_HOLD: assert property ($fell(cs_n_o) |-> !cs_n_o[*8])
    else $error("select released too early");
  AST_SCK_RUNS: assert property ($fell(cs_n_o) |-> ##[1:12] $changed(sck_o))
    else $error("link clock did not start");
  AST_SCK_PARKED: assert property
    (cmd_ready_o && $past(cmd_ready_o) |-> $stable(sck_o))
    else $error("link clock moved while idle");
  AST_DONE_AFTER_CS: assert property ($rose(cs_n_o) |-> ##[2:4] done_o)
    else $error("no completion after select rise");
  AST_DONE_PULSE: assert property
    (done_o |-> cmd_ready_o ##1 !done_o)
    else $error("completion pulse or ready wrong");
  AST_NO_WR_IDLE: assert property (cs_n_o |-> !wr_ready_o)
    else $error("write byte taken outside a frame");
  AST_RD_PULSE: assert property (rd_valid_o |=> !rd_valid_o)
    else $error("read valid longer than one cycle");
endmodule : sfh_ctrl_monitor

bind sfh_ctrl sfh_ctrl_monitor sfh_ctrl_monitor_i (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start_i),
  .cmd_ready_o(cmd_ready_o), .instr_i(instr_i), .cont_i(cont_i),
  .all_four_lane_mode_i(all_four_lane_mode_i), .wr_ready_o(wr_ready_o),
  .rd_valid_o(rd_valid_o), .done_o(done_o), .sck_o(sck_o),
  .cs_n_o(cs_n_o), .io_o(io_o), .io_oe_o(io_oe_o));

/* File: sfh_flash_model.sv */
`timescale 1ns/10ps
module sfh_flash_model #(
  parameter logic [7:0] RD24 = 8'h03,
  parameter logic [7:0] RD32 = 8'h13,
  parameter logic [7:0] RD2  = 8'h3B,
  parameter logic [7:0] PROG = 8'h02
) (
  // link from the host
  input  wire logic       sck_i,
  input  wire logic       cs_n_i,
  input  wire logic [3:0] hio_i,
  input  wire logic [3:0] hoe_i,
  // resolved lines seen by the host
  output logic      [3:0] io_o
);
  int          bits;
  int          alen;
  int          k;
  int          j;
  int          last_bits;
  int          ln;
  int          dum;
  logic [1:0]  dq = 2'h0;
  logic [7:0]  ins;
  logic [7:0]  last_ins;
  logic [31:0] adr;
  logic [7:0]  wb;
  logic [7:0]  bv;
  logic        drv = 1'b0;
  logic [7:0]  wq[$];

  assign alen = (ins == RD32) ? 32 : 24;
  // the instruction alone fixes data lanes and latency
  assign ln  = (ins == RD2) ? 2 : 1;
  assign dum = (ins == RD2) ? 8 : 0;

  // fresh counters per frame; only dq and wb carry over
  always @(negedge cs_n_i) begin
    bits = 0;
    ins = 8'h00;
    adr = 32'h0;
    wq.delete();
  end
  // frame end: bit count kept to judge byte boundary
  always @(posedge cs_n_i) begin
    last_bits = bits;
    last_ins = ins;
    drv = 1'b0;
  end
  // all inputs on rising edges, serial input only, msb first
  always @(posedge sck_i) if (!cs_n_i) begin
    k = bits - 8 - alen;
    if (bits < 8) ins = {ins[6:0], hio_i[0]};
    else if (k < 0) adr = {adr[30:0], hio_i[0]};
    else if (ins == PROG) begin
      wb = {wb[6:0], hio_i[0]};
      if (k % 8 == 7) wq.push_back(wb);
    end
    bits++;
  end
  // read data from the fall after the address and dummy bits; byte value counts up
  always @(negedge sck_i) if (!cs_n_i && bits >= 8 + alen + dum &&
      (ins == RD24 || ins == RD32 || ins == RD2)) begin
    j = (bits - 8 - alen - dum) * ln;
    bv = adr[7:0] + 8'(j / 8);
    dq = (ln == 2) ? {bv[7 - j % 8], bv[6 - j % 8]}
                   : {bv[7 - j % 8], 1'b0};
    drv = 1'b1;
  end
  // released lines never show a stale value; lanes 2 and 3 pulled up
  assign io_o[0] = (drv && ln == 2) ? dq[0]
                                    : (hoe_i[0] ? hio_i[0] : ~hio_i[0]);
  assign io_o[1] = drv ? dq[1] : (hoe_i[1] ? hio_i[1] : ~dq[1]);
  assign io_o[3:2] = (hoe_i[3:2] & hio_i[3:2]) | ~hoe_i[3:2];
endmodule : sfh_flash_model

/* File: test_sfh_ctrl.sv */
`timescale 1ns/10ps
module test_sfh_ctrl;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        start_i = 1'b0;
  logic [7:0]  instr_i = 8'h00;
  logic [31:0] addr_i = 32'h0;
  logic [2:0]  addr_bytes_i = 3'h0;
  logic [2:0]  addr_lanes_i = 3'h1;
  logic [2:0]  data_lanes_i = 3'h1;
  logic        mode_en_i = 1'b0;
  logic [7:0]  mode_i = 8'h00;
  logic [4:0]  dummy_i = 5'h00;
  logic        ddr_i = 1'b0;
  logic        cont_i = 1'b0;
  logic [15:0] wr_len_i = 16'h0;
  logic [15:0] rd_len_i = 16'h0;
  logic        cpol_i = 1'b0;
  logic        four_lane_enable_bit_i = 1'b0;
  logic        all_four_lane_mode_i = 1'b0;
  logic [7:0]  wr_data_i = 8'h00;
  logic        wr_valid_i = 1'b1;
  logic        cmd_ready_o, wr_ready_o, rd_valid_o, done_o;
  logic        sck_o, cs_n_o;
  logic [7:0]  rd_data_o;
  logic [3:0]  io_o, io_oe_o;
  wire  [3:0]  io_i;
  logic [7:0]  rq[$];
  int          n_fail = 0;
  int          comparisons = 0;
  int          cyc = 0;

  sfh_ctrl sfh_ctrl_i (.*);
  sfh_flash_model sfh_flash_model_i (.sck_i(sck_o), .cs_n_i(cs_n_o),
    .hio_i(io_o), .hoe_i(io_oe_o), .io_o(io_i));

  // 10 MHz system clock
  always #50 clk_i = ~clk_i;

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic close_out();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out

  // one command: wait for ready, take it, gather read bytes until done
  task automatic run(input logic [7:0] ins, input logic [2:0] ab,
                     input logic [31:0] a, input logic [15:0] wl,
                     input logic [15:0] rl, input logic pol);
    int n;
    n = 0;
    rq.delete();
    while (cmd_ready_o !== 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    @(posedge clk_i);
    #1;
    instr_i = ins;
    addr_bytes_i = ab;
    addr_i = a;
    wr_len_i = wl;
    rd_len_i = rl;
    cpol_i = pol;
    start_i = 1'b1;
    @(posedge clk_i);
    #1 start_i = 1'b0;
    n = 0;
    // sample mid-cycle so pulses are settled
    while (done_o !== 1'b1 && n < 20000) begin
      @(negedge clk_i);
      n++;
      if (rd_valid_o === 1'b1) rq.push_back(rd_data_o);
      if (wr_ready_o === 1'b1) @(posedge clk_i) #1 wr_data_i++;
    end
    chk("done seen", done_o, 1'b1);
  endtask : run

  // lone instruction in both clock modes, back to back
  task automatic t_alone();
    for (int m = 0; m < 2; m++) begin
      run(8'h06, 3'h0, 32'h0, 16'h0, 16'h0, m[0]);
      chk("alone instr", sfh_flash_model_i.last_ins, 8'h06);
      chk("alone bits", sfh_flash_model_i.last_bits, 8);
      chk("sck parked", sck_o, m[0]);
    end
  endtask : t_alone

  // reads of both address widths; first one wraps the byte value
  task automatic t_read();
    run(8'h03, 3'h3, 32'h000123FE, 16'h0, 16'h3, 1'b0);
    chk("rd24 count", rq.size(), 3);
    foreach (rq[i]) chk("rd24 byte", rq[i], 8'(8'hFE + i));
    chk("rd24 bits", sfh_flash_model_i.last_bits, 56);
    chk("rd24 addr", sfh_flash_model_i.adr, 32'h000123FE);
    run(8'h13, 3'h4, 32'h12345678, 16'h0, 16'h2, 1'b1);
    chk("rd32 count", rq.size(), 2);
    foreach (rq[i]) chk("rd32 byte", rq[i], 8'(8'h78 + i));
    chk("rd32 addr", sfh_flash_model_i.adr, 32'h12345678);
  endtask : t_read

  // two written bytes follow the address in order
  task automatic t_write();
    wr_data_i = 8'h5A;
    run(8'h02, 3'h3, 32'h00000100, 16'h2, 16'h0, 1'b0);
    chk("wr bits", sfh_flash_model_i.last_bits, 48);
    chk("wr count", sfh_flash_model_i.wq.size(), 2);
    chk("wr byte0", sfh_flash_model_i.wq[0], 8'h5A);
    chk("wr byte1", sfh_flash_model_i.wq[1], 8'h5B);
  endtask : t_write

  // dual output read: serial address, dummy cycles, data in pairs
  task automatic t_dual();
    data_lanes_i = 3'h2;
    dummy_i = 5'h08;
    run(8'h3B, 3'h3, 32'h000200A0, 16'h0, 16'h2, 1'b0);
    data_lanes_i = 3'h1;
    dummy_i = 5'h00;
    chk("dual count", rq.size(), 2);
    foreach (rq[i]) chk("dual byte", rq[i], 8'(8'hA0 + i));
    chk("dual bits", sfh_flash_model_i.last_bits, 48);
  endtask : t_dual

  // with a four-lane bit set, IO2 is released while idle
  task automatic t_lanes();
    @(posedge clk_i);
    #1 four_lane_enable_bit_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 chk("quad idle oe", io_oe_o, 4'h8);
    chk("quad idle io3", io_o[3], 1'b1);
    four_lane_enable_bit_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1 chk("plain idle oe", io_oe_o, 4'hC);
  endtask : t_lanes

  // hang guard, far above the few thousand cycles needed
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    repeat (12) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    // internal reset lifts two edges later; request from the third
    repeat (3) @(posedge clk_i);
    t_alone();
    t_read();
    t_write();
    t_dual();
    t_lanes();
    close_out();
  end
endmodule : test_sfh_ctrl
